// File: logic/asad_map.vh
/*
  Constants for the alternate-space access decoder: outcome kinds,
  instruction forms, privilege levels, space codes, offsets, register
  ids and the software-visible control map.
  Assumes it is included by bare name from the logic/ design files.
*/
`ifndef ASAD_MAP_VH
`define ASAD_MAP_VH
`define ASAD_K_REG 3'h0
`define ASAD_K_NOP 3'h1
`define ASAD_K_DAE 3'h2
`define ASAD_K_PRIV 3'h3
`define ASAD_K_MEM 3'h4
`define ASAD_K_DIAG 3'h5
`define ASAD_F_LDXA 3'h0
`define ASAD_F_STXA 3'h1
`define ASAD_F_LDDFA 3'h2
`define ASAD_F_STDFA 3'h3
`define ASAD_F_LDOTH 3'h4
`define ASAD_F_STOTH 3'h5
`define ASAD_PL_USER 2'h0
`define ASAD_PL_PRIV 2'h1
`define ASAD_PL_HYPER 2'h2
`define ASAD_CT_NONE 2'h0
`define ASAD_CT_UNASSIGNED 2'h3
`define ASAD_ASI_OPEN_BASE 8'h80
`define ASAD_ASI_HYPER_BASE 8'h30
`define ASAD_ASI_REAL_LE 8'h1c
`define ASAD_ASI_BIS_AIUP 8'h22
`define ASAD_ASI_BIS_AIUS 8'h23
`define ASAD_ASI_TWIN 8'h24
`define ASAD_ASI_BIS_N 8'h27
`define ASAD_ASI_BIS_AIUP_L 8'h2a
`define ASAD_ASI_BIS_AIUS_L 8'h2b
`define ASAD_ASI_TWIN_LE 8'h2c
`define ASAD_ASI_BIS_NL 8'h2f
`define ASAD_ASI_TSB_GRP 4'h3
`define ASAD_ASI_MA 8'h40
`define ASAD_ASI_BIST 8'h42
`define ASAD_ASI_MARGIN 8'h44
`define ASAD_ASI_LSUCTL 8'h45
`define ASAD_ASI_DC_DATA 8'h46
`define ASAD_ASI_DC_TAG 8'h47
`define ASAD_ASI_ERR_EN 8'h4b
`define ASAD_ASI_ERR_ST 8'h4c
`define ASAD_ASI_ERR_AD 8'h4d
`define ASAD_ASI_IMMU 8'h50
`define ASAD_ASI_ITSB_PTR 8'h51
`define ASAD_VA_ALIAS_MASK 8'hf8
`define ASAD_VA_ZERO 8'h00
`define ASAD_VA_MA_CTL 8'h80
`define ASAD_VA_MA_PA 8'h88
`define ASAD_VA_MODEXP_MEM_ADDR_REG 8'h90
`define ASAD_VA_MA_NP 8'h98
`define ASAD_VA_MA_WAIT 8'ha0
`define ASAD_VA_IMASK 8'h08
`define ASAD_VA_LSUDIAG 8'h10
`define ASAD_VA_IFSR 8'h18
`define ASAD_VA_IMMU_BAD 8'h28
`define ASAD_VA_ITAG 8'h30
`define ASAD_SH_MA_CTL 4'h0
`define ASAD_SH_MA_PA 4'h1
`define ASAD_SH_MODEXP_MEM_ADDR_REG 4'h2
`define ASAD_SH_MA_NP 4'h3
`define ASAD_SH_BIST 4'h4
`define ASAD_SH_IMASK 4'h5
`define ASAD_SH_LSUDIAG 4'h6
`define ASAD_SH_MARGIN 4'h7
`define ASAD_SH_ERR_EN 4'h8
`define ASAD_SH_COUNT 9
`define ASAD_ST_LSUCTL 5'h00
`define ASAD_ST_ERR_ST 5'h01
`define ASAD_ST_ERR_AD 5'h02
`define ASAD_ST_IFSR 5'h03
`define ASAD_ST_ITAG 5'h04
`define ASAD_ST_TSB_BASE 5'h08
`define ASAD_AX_CTRL 12'h000
`define ASAD_AX_STATUS 12'h004
`define ASAD_AX_DAE_CNT 12'h008
`define ASAD_AX_PRIV_CNT 12'h00c
`define ASAD_CTRL_RESET 1'b1
`define ASAD_RESP_OKAY 2'h0
`define ASAD_RESP_SLVERR 2'h2
`endif

// File: logic/asad_strand_rf.v
/*
  Per-strand register storage: 4 strands x 32 slots of 64 bits,
  one write port and one combinational read port.
  Assumes the caller resolves write/read conflicts; contents are
  undefined until first written.
*/
`timescale 1ns/10ps
`default_nettype none
module asad_strand_rf (
  input wire aclk,
  input wire we,
  input wire [6:0] waddr,
  input wire [63:0] wdata,
  input wire [6:0] raddr,
  output wire [63:0] rdata
);
  // data storage only, so no reset: keeps it mappable to a ram
  reg [63:0] mem [0:127];

  always @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule
`default_nettype wire

// File: logic/asad_axil_slave.v
/*
  AXI4-Lite slave front end: takes write address and data in either
  order, one write and one read at a time, registered responses.
  Assumes the parent decodes addresses combinationally (rd/wr ok).
*/
`timescale 1ns/10ps
`default_nettype none
`include "asad_map.vh"
module asad_axil_slave (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_awaddr,
  input wire s_awvalid,
  output reg s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output reg s_wready,
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  input wire [11:0] s_araddr,
  input wire s_arvalid,
  output reg s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready,
  output wire wr_en,
  output reg [11:0] wr_addr,
  output reg [31:0] wr_data,
  output reg [3:0] wr_strb,
  input wire wr_ok,
  input wire [31:0] rd_data,
  input wire rd_ok
);
  reg aw_hold_q;
  reg w_hold_q;

  assign wr_en = aw_hold_q & w_hold_q & ~s_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= `ASAD_RESP_OKAY;
      wr_addr <= 12'h000;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= `ASAD_RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_hold_q <= 1'b1;
        wr_addr <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_hold_q <= 1'b1;
        wr_data <= s_wdata;
        wr_strb <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (wr_en) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? `ASAD_RESP_OKAY : `ASAD_RESP_SLVERR;
      end
      // ready comes back only after the response is taken
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
      if (s_arvalid && s_arready) begin
        s_arready <= 1'b0;
        s_rvalid <= 1'b1;
        s_rdata <= rd_ok ? rd_data : 32'h00000000;
        s_rresp <= rd_ok ? `ASAD_RESP_OKAY : `ASAD_RESP_SLVERR;
      end
      if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/asad_top.v
/*
  Alternate-space access decoder and checker for one core. Classifies
  each access from the load/store pipeline, services internal
  registers, holds a strand on the modular-arithmetic wait offset and
  exposes counters over AXI4-Lite.
  Assumes requests, ma_busy and pointer inputs come from logic on aclk.
*/
// Local design decisions: the register offsets and register access over AXI4-Lite.
// Notes on behaviour
// - limited-range spaces drop upper address bits; no range fault.
// - internal non-translating spaces take only 64-bit integer forms.
// - floating doubleword forms on internal spaces raise a data exception.
// - spaces 80 through FF open to every privilege level.
// - spaces 00 through 2F need privileged or hyperprivileged level.
// - spaces 30 through 7F need hyperprivileged level.
// - unassigned spaces give data access exception, fault context type 3.
// - space 40 offsets 80/88/90/98 are core-shared arithmetic registers.
// - space 40 offset A0 holds the strand until arithmetic work finishes.
// - space 42: self-test, mask, diagnostic registers; rest no-op.
// - space 45 offset 0 is per-strand unit control; other offsets no-op.
// - spaces 46 and 47 give cache data and tag diagnostics at any address.
// - 4B shared error enable; 4C and 4D per-strand error status and address.
// - space 44 offset 0 is the core-shared margin control register.
// - space 50: tag target, fault status, tag access; 28 faults; rest no-op.
// - space 51 offset 0 reads the pointer; other loads no-op.
// - spaces 31-3F but 34/38/3C: per-strand table base/config registers.
// - spaces 24 and 2C are read-only twin loads, second little-endian.
// - stores to 22/23/27/2A/2B/2F are block-initializing with given context.
// - space 1C: real-address little-endian, no level-1 allocation.
`timescale 1ns/10ps
`default_nettype none
`include "asad_map.vh"
module asad_top (
  input wire aclk,
  input wire aresetn,
  input wire req_valid,
  output reg req_ready,
  input wire [7:0] req_asi,
  input wire [15:0] req_va,
  input wire [2:0] req_form,
  input wire [1:0] req_priv,
  input wire [1:0] req_strand,
  input wire [63:0] req_wdata,
  input wire ma_busy,
  input wire [63:0] itsb_ptr,
  input wire [63:0] itag_target,
  output reg rsp_valid,
  output reg [2:0] rsp_kind,
  output reg [1:0] rsp_ct,
  output reg [63:0] rsp_rdata,
  output reg [7:0] rsp_attr,
  output reg rsp_diag_tag,
  output reg ma_start,
  input wire [11:0] s_awaddr,
  input wire s_awvalid,
  output wire s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output wire s_wready,
  output wire [1:0] s_bresp,
  output wire s_bvalid,
  input wire s_bready,
  input wire [11:0] s_araddr,
  input wire s_arvalid,
  output wire s_arready,
  output wire [31:0] s_rdata,
  output wire [1:0] s_rresp,
  output wire s_rvalid,
  input wire s_rready
);
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;
  // attribute bits of a memory-style access
  localparam A_LE = 0;
  localparam A_NOALLOC = 1;
  localparam A_REAL = 2;
  localparam A_BIS = 3;
  localparam A_TWIN = 4;
  localparam A_AIU = 5;
  localparam A_SEC = 6;
  localparam A_NUC = 7;

  reg [1:0] state_q;
  reg [63:0] sh_q [0:`ASAD_SH_COUNT-1];
  reg ctrl_cnt_en_q;
  reg [31:0] dae_cnt_q;
  reg [31:0] priv_cnt_q;
  reg [7:0] last_asi_q;
  reg [1:0] last_ct_q;
  reg [2:0] last_kind_q;
  integer i;

  reg [2:0] d_kind;
  reg [1:0] d_ct;
  reg [7:0] d_attr;
  reg d_is_sh;
  reg d_is_st;
  reg [3:0] d_sh;
  reg [4:0] d_st;
  reg d_wait;
  reg d_diag;
  reg d_internal;
  reg d_ro;
  reg [63:0] d_rdata;

  wire [7:0] va8;
  wire is_store;
  wire form_ok;
  wire take;
  wire [63:0] rf_rdata;
  wire rf_we;

  // upper bits dropped: out-of-range offsets alias, never fault
  assign va8 = req_va[7:0] & `ASAD_VA_ALIAS_MASK;
  assign is_store = (req_form == `ASAD_F_STXA) ||
                    (req_form == `ASAD_F_STDFA) ||
                    (req_form == `ASAD_F_STOTH);
  assign form_ok = (req_form == `ASAD_F_LDXA) ||
                   (req_form == `ASAD_F_STXA);
  assign take = req_valid & req_ready & (state_q == ST_IDLE);

  // spaces that have no function in this core
  function is_unassigned;
    input [7:0] asi;
    begin
      case (asi)
        8'h00, 8'h01, 8'h02, 8'h03,
        8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b,
        8'h0d, 8'h0e, 8'h0f, 8'h12, 8'h13, 8'h1a, 8'h1b,
        8'h28, 8'h29, 8'h2d, 8'h30, 8'h34, 8'h38, 8'h3c,
        8'h41, 8'h48, 8'h49, 8'h4a, 8'h4e: is_unassigned = 1'b1;
        default: is_unassigned = 1'b0;
      endcase
    end
  endfunction

  always @* begin
    d_kind = `ASAD_K_MEM;
    d_ct = `ASAD_CT_NONE;
    d_attr = 8'h00;
    d_is_sh = 1'b0;
    d_is_st = 1'b0;
    d_sh = 4'h0;
    d_st = 5'h00;
    d_wait = 1'b0;
    d_diag = 1'b0;
    d_internal = 1'b1;
    d_ro = 1'b0;
    case (req_asi)
      `ASAD_ASI_REAL_LE: begin
        d_internal = 1'b0;
        d_attr[A_LE] = 1'b1;
        d_attr[A_NOALLOC] = 1'b1;
        d_attr[A_REAL] = 1'b1;
      end
      `ASAD_ASI_TWIN, `ASAD_ASI_TWIN_LE: begin
        d_internal = 1'b0;
        d_attr[A_TWIN] = 1'b1;
        d_attr[A_LE] = (req_asi == `ASAD_ASI_TWIN_LE);
        if (is_store) begin
          d_kind = `ASAD_K_DAE;
          d_ct = `ASAD_CT_UNASSIGNED;
        end
      end
      `ASAD_ASI_BIS_AIUP, `ASAD_ASI_BIS_AIUS, `ASAD_ASI_BIS_N,
      `ASAD_ASI_BIS_AIUP_L, `ASAD_ASI_BIS_AIUS_L, `ASAD_ASI_BIS_NL: begin
        d_internal = 1'b0;
        d_attr[A_TWIN] = ~is_store;
        d_attr[A_BIS] = is_store;
        d_attr[A_LE] = req_asi[3];
        d_attr[A_NUC] = (req_asi[2:0] == 3'h7);
        d_attr[A_AIU] = (req_asi[2:0] != 3'h7);
        d_attr[A_SEC] = req_asi[0] & (req_asi[2:0] != 3'h7);
      end
      `ASAD_ASI_MA: begin
        d_kind = `ASAD_K_REG;
        d_is_sh = 1'b1;
        case (va8)
          `ASAD_VA_MA_CTL: d_sh = `ASAD_SH_MA_CTL;
          `ASAD_VA_MA_PA: d_sh = `ASAD_SH_MA_PA;
          `ASAD_VA_MODEXP_MEM_ADDR_REG: d_sh = `ASAD_SH_MODEXP_MEM_ADDR_REG;
          `ASAD_VA_MA_NP: d_sh = `ASAD_SH_MA_NP;
          `ASAD_VA_MA_WAIT: begin
            d_kind = `ASAD_K_NOP;
            d_is_sh = 1'b0;
            d_wait = 1'b1;
          end
          default: begin
            d_kind = `ASAD_K_NOP;
            d_is_sh = 1'b0;
          end
        endcase
      end
      `ASAD_ASI_BIST: begin
        d_kind = `ASAD_K_REG;
        d_is_sh = 1'b1;
        case (va8)
          `ASAD_VA_ZERO: d_sh = `ASAD_SH_BIST;
          `ASAD_VA_IMASK: d_sh = `ASAD_SH_IMASK;
          `ASAD_VA_LSUDIAG: d_sh = `ASAD_SH_LSUDIAG;
          default: begin
            d_kind = `ASAD_K_NOP;
            d_is_sh = 1'b0;
          end
        endcase
      end
      `ASAD_ASI_MARGIN, `ASAD_ASI_ERR_EN: begin
        d_kind = (va8 == `ASAD_VA_ZERO) ? `ASAD_K_REG : `ASAD_K_NOP;
        d_is_sh = (va8 == `ASAD_VA_ZERO);
        d_sh = (req_asi == `ASAD_ASI_MARGIN) ? `ASAD_SH_MARGIN :
               `ASAD_SH_ERR_EN;
      end
      `ASAD_ASI_LSUCTL, `ASAD_ASI_ERR_ST, `ASAD_ASI_ERR_AD: begin
        d_kind = (va8 == `ASAD_VA_ZERO) ? `ASAD_K_REG : `ASAD_K_NOP;
        d_is_st = (va8 == `ASAD_VA_ZERO);
        d_st = (req_asi == `ASAD_ASI_LSUCTL) ? `ASAD_ST_LSUCTL :
               (req_asi == `ASAD_ASI_ERR_ST) ? `ASAD_ST_ERR_ST :
               `ASAD_ST_ERR_AD;
      end
      `ASAD_ASI_DC_DATA, `ASAD_ASI_DC_TAG: begin
        d_kind = `ASAD_K_DIAG;
        d_diag = req_asi[0];
      end
      `ASAD_ASI_IMMU: begin
        d_kind = `ASAD_K_REG;
        case (va8)
          `ASAD_VA_ZERO: d_ro = 1'b1;
          `ASAD_VA_IFSR: begin
            d_is_st = 1'b1;
            d_st = `ASAD_ST_IFSR;
          end
          `ASAD_VA_ITAG: begin
            d_is_st = 1'b1;
            d_st = `ASAD_ST_ITAG;
          end
          `ASAD_VA_IMMU_BAD: begin
            d_kind = `ASAD_K_DAE;
            d_ct = `ASAD_CT_UNASSIGNED;
          end
          default: d_kind = `ASAD_K_NOP;
        endcase
      end
      `ASAD_ASI_ITSB_PTR: begin
        d_kind = (va8 == `ASAD_VA_ZERO && !is_store) ?
                 `ASAD_K_REG : `ASAD_K_NOP;
        d_ro = 1'b1;
      end
      default: begin
        if (req_asi[7:4] == `ASAD_ASI_TSB_GRP && req_asi[1:0] != 2'h0) begin
          d_kind = (va8 == `ASAD_VA_ZERO) ? `ASAD_K_REG : `ASAD_K_NOP;
          d_is_st = (va8 == `ASAD_VA_ZERO);
          d_st = `ASAD_ST_TSB_BASE + {1'b0, req_asi[3:2], 2'h0} +
                 {3'h0, req_asi[1:0]} - 5'h01;
        end else begin
          d_internal = 1'b0;
        end
      end
    endcase
    if (is_unassigned(req_asi)) begin
      d_kind = `ASAD_K_DAE;
      d_ct = `ASAD_CT_UNASSIGNED;
    end else if (d_internal && !form_ok) begin
      // floating and sub-word forms cannot reach internal state
      d_kind = `ASAD_K_DAE;
      d_ct = `ASAD_CT_UNASSIGNED;
    end
    // privilege checked last so it outranks every other outcome
    if ((req_asi < `ASAD_ASI_HYPER_BASE && req_priv == `ASAD_PL_USER) ||
        (req_asi >= `ASAD_ASI_HYPER_BASE && req_asi < `ASAD_ASI_OPEN_BASE &&
         req_priv != `ASAD_PL_HYPER)) begin
      d_kind = `ASAD_K_PRIV;
      d_ct = `ASAD_CT_NONE;
    end
    if (d_kind != `ASAD_K_MEM) begin
      d_attr = 8'h00;
    end
  end

  always @* begin
    d_rdata = 64'h0000000000000000;
    if (d_kind == `ASAD_K_REG && !is_store) begin
      if (d_is_sh) begin
        d_rdata = sh_q[d_sh];
      end else if (d_is_st) begin
        d_rdata = rf_rdata;
      end else if (req_asi == `ASAD_ASI_ITSB_PTR) begin
        d_rdata = itsb_ptr;
      end else if (d_ro) begin
        d_rdata = itag_target;
      end
    end
  end

  // store data reaches storage only on a clean register outcome
  assign rf_we = take & is_store & d_is_st & (d_kind == `ASAD_K_REG);

  asad_strand_rf u_rf (
    .aclk(aclk),
    .we(rf_we),
    .waddr({req_strand, d_st}),
    .wdata(req_wdata),
    .raddr({req_strand, d_st}),
    .rdata(rf_rdata)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_kind <= `ASAD_K_NOP;
      rsp_ct <= `ASAD_CT_NONE;
      rsp_rdata <= 64'h0000000000000000;
      rsp_attr <= 8'h00;
      rsp_diag_tag <= 1'b0;
      ma_start <= 1'b0;
      for (i = 0; i < `ASAD_SH_COUNT; i = i + 1) begin
        sh_q[i] <= 64'h0000000000000000;
      end
    end else begin
      rsp_valid <= 1'b0;
      ma_start <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            rsp_kind <= d_kind;
            rsp_ct <= d_ct;
            rsp_rdata <= d_rdata;
            rsp_attr <= d_attr;
            rsp_diag_tag <= d_diag;
            if (is_store && d_is_sh && d_kind == `ASAD_K_REG) begin
              sh_q[d_sh] <= req_wdata;
              ma_start <= (d_sh == `ASAD_SH_MA_CTL);
            end
            if (d_wait && d_kind == `ASAD_K_NOP) begin
              state_q <= ST_WAIT;
              req_ready <= 1'b0;
            end else begin
              rsp_valid <= 1'b1;
            end
          end
        end
        ST_WAIT: begin
          // a start pulse this cycle still counts as busy
          if (!ma_busy && !ma_start) begin
            state_q <= ST_IDLE;
            req_ready <= 1'b1;
            rsp_valid <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          req_ready <= 1'b1;
        end
      endcase
    end
  end

  wire ax_wr_en;
  wire [11:0] ax_wr_addr;
  wire [31:0] ax_wr_data;
  wire [3:0] ax_wr_strb;
  reg ax_rd_ok;
  reg [31:0] ax_rd_data;
  wire ax_wr_ok;
  wire clr_cnt;
  wire cnt_dae;
  wire cnt_priv;

  assign ax_wr_ok = (ax_wr_addr == `ASAD_AX_CTRL);
  assign clr_cnt = ax_wr_en & ax_wr_ok & ax_wr_strb[0] & ax_wr_data[1];
  assign cnt_dae = rsp_valid & ctrl_cnt_en_q & (rsp_kind == `ASAD_K_DAE);
  assign cnt_priv = rsp_valid & ctrl_cnt_en_q & (rsp_kind == `ASAD_K_PRIV);

  always @* begin
    ax_rd_ok = 1'b1;
    case (s_araddr)
      `ASAD_AX_CTRL: ax_rd_data = {31'h00000000, ctrl_cnt_en_q};
      `ASAD_AX_STATUS: ax_rd_data = {11'h000, last_kind_q, last_ct_q,
                                     last_asi_q, 7'h00,
                                     (state_q == ST_WAIT)};
      `ASAD_AX_DAE_CNT: ax_rd_data = dae_cnt_q;
      `ASAD_AX_PRIV_CNT: ax_rd_data = priv_cnt_q;
      default: begin
        ax_rd_ok = 1'b0;
        ax_rd_data = 32'h00000000;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_cnt_en_q <= `ASAD_CTRL_RESET;
      dae_cnt_q <= 32'h00000000;
      priv_cnt_q <= 32'h00000000;
      last_asi_q <= 8'h00;
      last_ct_q <= `ASAD_CT_NONE;
      last_kind_q <= `ASAD_K_NOP;
    end else begin
      if (ax_wr_en && ax_wr_ok && ax_wr_strb[0]) begin
        ctrl_cnt_en_q <= ax_wr_data[0];
      end
      // a fault in the clearing cycle survives as a count of one
      dae_cnt_q <= (clr_cnt ? 32'h00000000 : dae_cnt_q) +
                   {31'h00000000, cnt_dae};
      priv_cnt_q <= (clr_cnt ? 32'h00000000 : priv_cnt_q) +
                    {31'h00000000, cnt_priv};
      if (take && (d_kind == `ASAD_K_DAE || d_kind == `ASAD_K_PRIV)) begin
        last_asi_q <= req_asi;
        last_ct_q <= d_ct;
        last_kind_q <= d_kind;
      end
    end
  end

  asad_axil_slave u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(ax_wr_en),
    .wr_addr(ax_wr_addr),
    .wr_data(ax_wr_data),
    .wr_strb(ax_wr_strb),
    .wr_ok(ax_wr_ok),
    .rd_data(ax_rd_data),
    .rd_ok(ax_rd_ok)
  );
endmodule
`default_nettype wire

// File: tb/asad_ma_model.sv
/*
  Arithmetic engine stand-in: busy for a set time after start.
  Assumes start is a one-cycle pulse on aclk.
*/
`timescale 1ns/10ps
`default_nettype none
module asad_ma_model #(
  parameter int BUSY = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ma_start,
  output logic ma_busy
);
  logic [7:0] left_q;
  always @(posedge aclk) begin
    if (!aresetn)
      left_q <= 8'h00;
    else if (ma_start)
      left_q <= BUSY[7:0];
    else if (left_q != 8'h00)
      left_q <= left_q - 8'h01;
  end
  // long enough to expose a missing hold
  assign ma_busy = left_q != 8'h00;
endmodule
`default_nettype wire

// File: tb/asad_assertions.sv
/*
  Checker for asad_top ports: kinds, fault codes, arithmetic hold.
  Assumes a bind into asad_top by port name.
*/
`timescale 1ns/10ps
`default_nettype none
`include "asad_map.vh"
module asad_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_asi,
  input wire logic [15:0] req_va,
  input wire logic [2:0] req_form,
  input wire logic [1:0] req_priv,
  input wire logic ma_busy,
  input wire logic rsp_valid,
  input wire logic [2:0] rsp_kind,
  input wire logic [1:0] rsp_ct,
  input wire logic ma_start
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire tk = req_valid && req_ready;
  wire hy = tk && req_priv == `ASAD_PL_HYPER;
  wire x = req_form == `ASAD_F_LDXA || req_form == `ASAD_F_STXA;
  wire ma = hy && req_asi == `ASAD_ASI_MA;
  wire dae = rsp_kind == `ASAD_K_DAE;
  wire c3 = rsp_ct == `ASAD_CT_UNASSIGNED;
  wire pa = rsp_valid && rsp_kind == `ASAD_K_PRIV;
  user_refused_a: assert property (
    tk && req_priv == `ASAD_PL_USER && !req_asi[7] |=> pa)
    else $error("user not refused");
  hyper_only_a: assert property (
    tk && req_priv == `ASAD_PL_PRIV && req_asi[7:4] >= 4'h3 && !req_asi[7]
    |=> pa) else $error("priv not refused");
  open_space_a: assert property (
    tk && req_asi[7] |=> rsp_valid && !pa) else $error("open refused");
  internal_form_a: assert property (
    hy && req_asi[7:2] == 6'h11 && !x |=> dae && c3)
    else $error("bad form passed");
  unassigned_a: assert property (
    hy && (req_asi[7:2] == 6'h00 || req_asi == 8'h41 || req_asi == 8'h4e)
    |=> dae && c3) else $error("unassigned passed");
  ct_match_a: assert property (
    rsp_valid |-> dae == c3) else $error("ct mismatch");
  ma_launch_a: assert property (
    ma && req_form == `ASAD_F_STXA && req_va[7:3] == 5'h10 |=> ma_start)
    else $error("no ma start");
  ma_hold_a: assert property (
    ma && x && req_va[7:3] == 5'h14 |=> !req_ready ##1
    (!req_ready || !$past(ma_busy))) else $error("wait not held");
  ma_release_a: assert property (
    !req_ready && !ma_busy |-> ##[1:2] rsp_valid && req_ready)
    else $error("wait not left");
endmodule
bind asad_top asad_chk u_chk (.*);
`default_nettype wire

// File: tb/test_alt_space_access_decoder.sv
/*
  Bench for asad_top: scenario tasks on the request port and AXI.
  Assumes the model and checker files are compiled with it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "asad_map.vh"
module test_alt_space_access_decoder;
  localparam logic [2:0] LD = `ASAD_F_LDXA, ST = `ASAD_F_STXA,
    KR = `ASAD_K_REG, KN = `ASAD_K_NOP, KD = `ASAD_K_DAE,
    KP = `ASAD_K_PRIV, KM = `ASAD_K_MEM, KG = `ASAD_K_DIAG;
  localparam logic [1:0] P = `ASAD_PL_PRIV, H = `ASAD_PL_HYPER,
    OK = `ASAD_RESP_OKAY, ER = `ASAD_RESP_SLVERR;
  logic aclk = 1'b0, aresetn = 1'b0, req_valid = 1'b0, s_awvalid = 1'b0;
  logic s_wvalid = 1'b0, s_bready = 1'b1, s_arvalid = 1'b0, s_rready = 1'b1;
  logic [7:0] req_asi = 8'h00;
  logic [15:0] req_va = 16'h0000;
  logic [2:0] req_form = 3'h0;
  logic [1:0] req_priv = 2'h0, req_strand = 2'h0;
  logic [63:0] req_wdata = 64'h0, itsb_ptr = 64'h5151_0000_0000_0008;
  logic [63:0] itag_target = 64'h5050_0000_0000_0030;
  logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'h1;
  logic req_ready, rsp_valid, rsp_diag_tag, ma_start, ma_busy, s_awready;
  logic s_wready, s_bvalid, s_arready, s_rvalid;
  logic [2:0] rsp_kind;
  logic [1:0] rsp_ct, s_bresp, s_rresp;
  logic [7:0] rsp_attr;
  logic [63:0] rsp_rdata;
  logic [31:0] s_rdata;
  logic [19:0] e;
  logic [15:0] rt [10] = '{16'h4400, 16'h4500, 16'h4b00, 16'h4c00,
    16'h4200, 16'h4208, 16'h4210, 16'h4088, 16'h3100, 16'h5018};
  logic [19:0] dt [10] = '{20'h45002, 20'h4b003, 20'h46004, 20'h47005,
    20'h41000, 20'h4e000, 20'h34000, 20'h02000, 20'h50280, 20'h24001};
  logic [19:0] mt [9] = '{20'h1c007, 20'h22128, 20'h23168, 20'h27188,
    20'h2a129, 20'h2b169, 20'h2f189, 20'h24010, 20'h2c011};
  int err_count = 0, check_count = 0;
  time t0;
  asad_top dut (.*);
  asad_ma_model u_ma (.aclk(aclk), .aresetn(aresetn),
    .ma_start(ma_start), .ma_busy(ma_busy));
  always #5 aclk = ~aclk;
  task chk(input logic [63:0] g, e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task acc(input logic [7:0] a, logic [15:0] v, logic [2:0] f,
    logic [1:0] p, logic [63:0] d, logic [2:0] k);
    {req_asi, req_va, req_form, req_priv, req_wdata} <= {a, v, f, p, d};
    req_valid <= 1'b1;
    @(posedge aclk iff req_ready === 1'b1);
    req_valid <= 1'b0;
    @(posedge aclk iff rsp_valid === 1'b1);
    chk(rsp_kind, k);
    chk(rsp_ct, k == KD ? 2'h3 : 2'h0);
  endtask
  // both readies rise together
  task axw(input logic [11:0] a, logic [31:0] d, logic [1:0] r);
    s_awaddr <= a;
    s_wdata <= d;
    {s_awvalid, s_wvalid} <= 2'b11;
    @(posedge aclk iff s_awready === 1'b1 && s_wready === 1'b1);
    {s_awvalid, s_wvalid} <= 2'b00;
    @(posedge aclk iff s_bvalid === 1'b1);
    chk(s_bresp, r);
  endtask
  task axr(input logic [11:0] a, logic [31:0] d, logic [1:0] r);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    @(posedge aclk iff s_arready === 1'b1);
    s_arvalid <= 1'b0;
    @(posedge aclk iff s_rvalid === 1'b1);
    chk(s_rdata, d);
    chk(s_rresp, r);
  endtask
  task t_priv;
    acc(8'h80, 16'h0, LD, 2'h0, 0, KM);
    acc(8'h1c, 16'h0, LD, 2'h0, 0, KP);
    acc(8'h1c, 16'h0, LD, P, 0, KM);
    acc(8'h7f, 16'h0, LD, P, 0, KP);
    acc(8'h45, 16'h0, ST, H, 64'h11, KR);
    acc(8'h45, 16'h0, ST, P, 64'h22, KP);
    acc(8'h45, 16'h0, LD, H, 0, KR);
    chk(rsp_rdata, 64'h11);
    $display("t_priv done");
  endtask
  task t_reg;
    for (int i = 0; i < 10; i++) begin
      e = rt[i];
      acc(e[15:8], e[7:0], ST, H, {48'h0, e[15:0]}, KR);
      acc(e[15:8], e[7:0], LD, H, 0, KR);
      chk(rsp_rdata, {48'h0, e[15:0]});
    end
    acc(8'h44, 16'h0100, LD, H, 0, KR);
    chk(rsp_rdata, 64'h4400);
    req_strand <= 2'h2;
    acc(8'h4b, 16'h0, LD, H, 0, KR);
    chk(rsp_rdata, 64'h4b00);
    acc(8'h4c, 16'h0, ST, H, 64'h2c, KR);
    req_strand <= 2'h0;
    acc(8'h4c, 16'h0, LD, H, 0, KR);
    chk(rsp_rdata, 64'h4c00);
    acc(8'h45, 16'h0008, ST, H, 64'h99, KN);
    acc(8'h42, 16'h00f8, LD, H, 0, KN);
    chk(rsp_rdata, 64'h0);
    acc(8'h45, 16'h0, LD, H, 0, KR);
    chk(rsp_rdata, 64'h4500);
    $display("t_reg done");
  endtask
  task t_dae;
    for (int i = 0; i < 10; i++) begin
      e = dt[i];
      acc(e[19:12], e[11:4], e[2:0], H, 0, KD);
    end
    $display("t_dae done");
  endtask
  task t_mem;
    for (int i = 0; i < 9; i++) begin
      e = mt[i];
      acc(e[19:12], 16'h0, e[10:8], H, 0, KM);
      chk(rsp_attr, e[7:0]);
    end
    acc(8'h46, 16'h00f8, LD, H, 0, KG);
    chk(rsp_diag_tag, 1'b0);
    acc(8'h47, 16'h01e0, ST, H, 64'h7, KG);
    chk(rsp_diag_tag, 1'b1);
    acc(8'h51, 16'h0, LD, H, 0, KR);
    chk(rsp_rdata, itsb_ptr);
    acc(8'h51, 16'h0008, LD, H, 0, KN);
    acc(8'h50, 16'h0, LD, H, 0, KR);
    chk(rsp_rdata, itag_target);
    $display("t_mem done");
  endtask
  task t_ma;
    acc(8'h40, 16'h0080, ST, H, 64'h1, KR);
    t0 = $time;
    acc(8'h40, 16'h00a0, LD, H, 0, KN);
    chk(ma_busy, 1'b0);
    chk($time - t0 > 70, 1'b1);
    $display("t_ma done");
  endtask
  task t_axi;
    axr(12'h000, 32'h1, OK);
    axw(12'h000, 32'h3, OK);
    acc(8'h41, 16'h0, LD, H, 0, KD);
    acc(8'h4e, 16'h0, LD, H, 0, KD);
    acc(8'h1c, 16'h0, ST, 2'h0, 0, KP);
    axr(12'h008, 32'h2, OK);
    axr(12'h00c, 32'h1, OK);
    axr(12'h004, 32'h000c1c00, OK);
    axr(12'h010, 32'h0, ER);
    axw(12'h008, 32'h5, ER);
    axr(12'h008, 32'h2, OK);
    $display("t_axi done");
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_priv;
    t_reg;
    t_dae;
    t_mem;
    t_ma;
    t_axi;
    give_verdict;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
